//--- mdrx_frame_end.sv
// mdrx_frame_end: multi-dwell receive frame end handling and hop policy
// assumes segments arrive already decoded, one per seg_valid pulse, and
// that the upper layer drains released data with a valid/ready handshake
// How it works
// - on end of frame, hand all buffered segments to the upper layer
// - frame end is decided from the carried end-of-frame flag or a third bad segment count in a row
// - bit sync lost before end flag releases every buffered segment
// - under three bad segment counts, keep predicted position, no slip
// - multi-dwell acks and single coding block messages use six-segment format
// - encapsulated bits are timed at the realised data rate
// - without hop timing, assume a hop at every hop slot
// - hops are detected from the radio hop-sync output
// - ack not fitting one dwell uses format 3, variant 3:5, 6 segments
// - acks use multi-dwell unless the current dwell is known long
// - length-affecting ack settings come only from network config
// - unknown dwell length means assume worst-case hop in every slot
// - the first packet of a frame has segment count zero
// - after a packet's last bit, open the start pattern window
`timescale 1ns/1ps
module mdrx_frame_end (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // receive segment stream from the demodulator
  input wire logic frame_start,
  input wire logic bit_sync,
  input wire logic seg_valid,
  input wire logic [mdrx_pkg::SEG_W-1:0] seg_data,
  input wire logic pkt_last_bit,
  // packet start pattern and decoded segment count
  input wire logic packet_start_pattern,
  input wire logic [mdrx_pkg::SEG_AW:0] seg_count,
  input wire logic seg_count_ok,
  input wire logic eof_flag,
  // upper layer delivery
  output logic out_valid,
  output logic [mdrx_pkg::SEG_W-1:0] out_data,
  output logic out_last,
  input wire logic out_ready,
  // radio hop timing
  input wire logic hop_sync,
  input wire logic hop_info_avail,
  input wire logic dwell_len_known,
  input wire logic dwell_long_known,
  input wire logic slot_tick,
  output logic hop_event,
  output logic assume_hop_all,
  output logic corr_window_open,
  // realised rate timing
  input wire logic [mdrx_pkg::ACC_W-1:0] realised_rate_inc,
  output logic eff_bit_tick,
  // acknowledgement format selection
  input wire logic single_block_msg,
  input wire logic [1:0] net_fec_cfg,
  input wire logic [1:0] net_dispersive_coding_block,
  input wire logic [1:0] long_dwell_fmt,
  output logic ack_multidwell,
  output logic [1:0] ack_frame_fmt,
  output logic [2:0] ack_message_variant_major,
  output logic [2:0] ack_message_variant_minor,
  output logic [2:0] tx_segments,
  output logic [1:0] ack_fec,
  output logic [1:0] ack_dispersive_coding_block
);

  localparam int AW = mdrx_pkg::SEG_AW;
  localparam int SW = mdrx_pkg::SEG_W;
  typedef struct packed {
    mdrx_pkg::mdrx_state_t st;
    logic [AW:0] wptr;
    logic [AW:0] hw;
    logic [AW-1:0] rptr;
    logic [1:0] bad;
    logic corr;
    logic hs_q;
    logic hop;
    logic [mdrx_pkg::ACC_W-1:0] acc;
    logic etick;
    logic hop_all;
    logic ack_md;
    logic [1:0] fmt;
    logic [2:0] mv_maj;
    logic [2:0] mv_min;
    logic [2:0] segs;
    logic [1:0] fec;
    logic [1:0] dcb;
  } mdrx_regs_t;
  mdrx_regs_t s_ff;
  mdrx_regs_t nxt_s;
  logic wr_en;
  logic [SW-1:0] rd_data;
  logic sop_take;
  logic hop_edge;
  logic [mdrx_pkg::ACC_W:0] acc_sum;
  // start of release: go read unless nothing is buffered
  function automatic mdrx_pkg::mdrx_state_t release_to(
    input logic [AW:0] hw
  );
    return (hw == mdrx_pkg::SEG_ZERO) ? mdrx_pkg::MDRX_IDLE
                                      : mdrx_pkg::MDRX_READ;
  endfunction
  // larger of high-water mark and next write position
  function automatic logic [AW:0] max_hw(
    input logic [AW:0] hw,
    input logic [AW:0] pos
  );
    return (pos > hw) ? pos : hw;
  endfunction
  mdrx_seg_mem u_mem (
    .clock(clock),
    .rstn(rstn),
    .wr_en(wr_en),
    .wr_addr(s_ff.wptr[AW-1:0]),
    .wr_data(seg_data),
    .rd_addr(s_ff.rptr),
    .rd_data(rd_data)
  );
  // handshake and strobes decoded from the state
  assign sop_take = packet_start_pattern && s_ff.corr;
  assign wr_en = (s_ff.st == mdrx_pkg::MDRX_RECV) && seg_valid &&
                 (s_ff.wptr < mdrx_pkg::SEG_DEPTH);
  assign hop_edge = hop_sync && !s_ff.hs_q;
  assign acc_sum = {1'b0, s_ff.acc} + {1'b0, realised_rate_inc};
  assign out_valid = (s_ff.st == mdrx_pkg::MDRX_OUT);
  assign out_last = out_valid &&
                    ({1'b0, s_ff.rptr} + mdrx_pkg::SEG_ONE == s_ff.hw);
  assign out_data = rd_data;
  assign hop_event = s_ff.hop;
  assign assume_hop_all = s_ff.hop_all;
  assign corr_window_open = s_ff.corr;
  assign eff_bit_tick = s_ff.etick;
  assign ack_multidwell = s_ff.ack_md;
  assign ack_frame_fmt = s_ff.fmt;
  assign ack_message_variant_major = s_ff.mv_maj;
  assign ack_message_variant_minor = s_ff.mv_min;
  assign tx_segments = s_ff.segs;
  assign ack_fec = s_ff.fec;
  assign ack_dispersive_coding_block = s_ff.dcb;
  // next-state logic for receive control, hop policy and ack format
  always_comb begin
    nxt_s = s_ff;
    nxt_s.hs_q = hop_sync;
    nxt_s.acc = acc_sum[mdrx_pkg::ACC_W-1:0];
    nxt_s.etick = acc_sum[mdrx_pkg::ACC_W];
    nxt_s.hop_all = !hop_info_avail || !dwell_len_known;
    nxt_s.hop = (hop_info_avail && hop_edge) ||
                (nxt_s.hop_all && slot_tick);
    nxt_s.ack_md = !dwell_long_known;
    nxt_s.fec = net_fec_cfg;
    nxt_s.dcb = net_dispersive_coding_block;
    nxt_s.fmt = dwell_long_known ? long_dwell_fmt
                                 : mdrx_pkg::ACK_FRAME_FMT;
    nxt_s.mv_maj = mdrx_pkg::ACK_MV_MAJOR;
    nxt_s.mv_min = mdrx_pkg::ACK_MV_MINOR;
    nxt_s.segs = (!dwell_long_known || single_block_msg) ?
                 mdrx_pkg::ACK_SEGMENTS : mdrx_pkg::SINGLE_DWELL_SEGS;
    case (s_ff.st)
      mdrx_pkg::MDRX_IDLE: begin
        if (frame_start) begin
          nxt_s.st = mdrx_pkg::MDRX_RECV;
          nxt_s.wptr = mdrx_pkg::SEG_ZERO;
          nxt_s.hw = mdrx_pkg::SEG_ZERO;
          nxt_s.bad = '0;
          nxt_s.corr = 1'b0;
        end
      end
      mdrx_pkg::MDRX_RECV: begin
        if (wr_en) begin
          nxt_s.wptr = s_ff.wptr + mdrx_pkg::SEG_ONE;
          nxt_s.hw = max_hw(s_ff.hw, s_ff.wptr + mdrx_pkg::SEG_ONE);
        end
        if (pkt_last_bit) begin
          nxt_s.corr = 1'b1;
        end
        if (!bit_sync) begin
          nxt_s.st = release_to(nxt_s.hw);
          nxt_s.corr = 1'b0;
        end else if (sop_take) begin
          nxt_s.corr = 1'b0;
          if (seg_count_ok) begin
            nxt_s.bad = '0;
            nxt_s.wptr = seg_count;
            if (eof_flag) begin
              nxt_s.hw = seg_count;
              nxt_s.st = release_to(seg_count);
            end
          end else if (s_ff.bad + mdrx_pkg::BAD_ONE ==
                       mdrx_pkg::BAD_RUN_LIMIT) begin
            nxt_s.st = release_to(nxt_s.hw);
          end else begin
            nxt_s.bad = s_ff.bad + mdrx_pkg::BAD_ONE;
            if (eof_flag) begin
              nxt_s.st = release_to(nxt_s.hw);
            end
          end
        end
      end
      mdrx_pkg::MDRX_READ: begin
        nxt_s.st = mdrx_pkg::MDRX_OUT;
      end
      mdrx_pkg::MDRX_OUT: begin
        if (out_ready) begin
          if (out_last) begin
            nxt_s.st = mdrx_pkg::MDRX_IDLE;
            nxt_s.wptr = mdrx_pkg::SEG_ZERO;
            nxt_s.hw = mdrx_pkg::SEG_ZERO;
            nxt_s.rptr = '0;
            nxt_s.bad = '0;
          end else begin
            nxt_s.rptr = s_ff.rptr + 1'b1;
            nxt_s.st = mdrx_pkg::MDRX_READ;
          end
        end
      end
      default: begin
        nxt_s.st = mdrx_pkg::MDRX_IDLE;
      end
    endcase
    // release with nothing buffered still clears tracking
    if (s_ff.st == mdrx_pkg::MDRX_RECV &&
        nxt_s.st == mdrx_pkg::MDRX_IDLE) begin
      nxt_s.wptr = mdrx_pkg::SEG_ZERO;
      nxt_s.bad = '0;
      nxt_s.rptr = '0;
    end
  end
  // state register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_ff <= '{st: mdrx_pkg::MDRX_IDLE, fmt: mdrx_pkg::ACK_FRAME_FMT,
                mv_maj: mdrx_pkg::ACK_MV_MAJOR,
                mv_min: mdrx_pkg::ACK_MV_MINOR,
                segs: mdrx_pkg::ACK_SEGMENTS, ack_md: 1'b1,
                hop_all: 1'b1, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end
  // checks on the design's own behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_eof_release;
    s_ff.st == mdrx_pkg::MDRX_RECV && bit_sync && sop_take &&
    seg_count_ok && eof_flag && seg_count != mdrx_pkg::SEG_ZERO
    |=> s_ff.st == mdrx_pkg::MDRX_READ ##1 out_valid;
  endproperty
  a_eof_release: assert property (p_eof_release)
    else $error("end of frame did not release buffer");
  property p_eof_only;
    s_ff.st == mdrx_pkg::MDRX_RECV && bit_sync && !sop_take
    |=> s_ff.st == mdrx_pkg::MDRX_RECV;
  endproperty
  a_eof_only: assert property (p_eof_only)
    else $error("frame ended without end-of-frame flag");
  property p_sync_loss;
    s_ff.st == mdrx_pkg::MDRX_RECV && !bit_sync &&
    s_ff.hw != mdrx_pkg::SEG_ZERO
    |=> s_ff.st == mdrx_pkg::MDRX_READ;
  endproperty
  a_sync_loss: assert property (p_sync_loss)
    else $error("sync loss did not release buffer");
  property p_pad;
    s_ff.st == mdrx_pkg::MDRX_RECV && bit_sync && sop_take &&
    !seg_count_ok && !eof_flag && s_ff.bad == '0 && !wr_en
    |=> s_ff.wptr == $past(s_ff.wptr) && s_ff.bad == mdrx_pkg::BAD_ONE;
  endproperty
  a_pad: assert property (p_pad)
    else $error("bad segment count moved write position");
  property p_six_seg;
    single_block_msg |=> tx_segments == mdrx_pkg::ACK_SEGMENTS;
  endproperty
  a_six_seg: assert property (p_six_seg)
    else $error("single block message not six segments");
  property p_rate;
    eff_bit_tick |-> $past(realised_rate_inc) != '0;
  endproperty
  a_rate: assert property (p_rate)
    else $error("bit tick without realised rate");
  property p_hop_slot;
    !hop_info_avail && slot_tick |=> hop_event && assume_hop_all;
  endproperty
  a_hop_slot: assert property (p_hop_slot)
    else $error("no assumed hop at slot");
  property p_hop_det;
    hop_info_avail && dwell_len_known && $rose(hop_sync) |=> hop_event;
  endproperty
  a_hop_det: assert property (p_hop_det)
    else $error("hop sync edge not detected");
  property p_ack_fmt;
    !dwell_long_known |=> ack_multidwell &&
      ack_frame_fmt == mdrx_pkg::ACK_FRAME_FMT &&
      ack_message_variant_major == mdrx_pkg::ACK_MV_MAJOR &&
      ack_message_variant_minor == mdrx_pkg::ACK_MV_MINOR &&
      tx_segments == mdrx_pkg::ACK_SEGMENTS;
  endproperty
  a_ack_fmt: assert property (p_ack_fmt)
    else $error("short dwell ack format wrong");
  property p_long_dwell;
    dwell_long_known && !single_block_msg |=> !ack_multidwell;
  endproperty
  a_long_dwell: assert property (p_long_dwell)
    else $error("long dwell still multi-dwell");
  property p_net_cfg;
    1'b1 |=> ack_fec == $past(net_fec_cfg) &&
      ack_dispersive_coding_block == $past(net_dispersive_coding_block);
  endproperty
  a_net_cfg: assert property (p_net_cfg)
    else $error("ack settings differ from network config");
  property p_worst_hop;
    !dwell_len_known && slot_tick |=> hop_event && assume_hop_all;
  endproperty
  a_worst_hop: assert property (p_worst_hop)
    else $error("unknown dwell did not assume hop");
  property p_first_zero;
    s_ff.st == mdrx_pkg::MDRX_IDLE && frame_start
    |=> s_ff.st == mdrx_pkg::MDRX_RECV && s_ff.wptr == mdrx_pkg::SEG_ZERO;
  endproperty
  a_first_zero: assert property (p_first_zero)
    else $error("first packet count not zero");
  property p_corr;
    s_ff.st == mdrx_pkg::MDRX_RECV && bit_sync && pkt_last_bit && !sop_take
    |=> corr_window_open;
  endproperty
  a_corr: assert property (p_corr)
    else $error("window not opened after last bit");
  property p_clear;
    out_ready && out_last
    |=> s_ff.st == mdrx_pkg::MDRX_IDLE && s_ff.hw == mdrx_pkg::SEG_ZERO;
  endproperty
  a_clear: assert property (p_clear)
    else $error("buffer not cleared after release");
  c_eof: cover property (sop_take && eof_flag ##[1:4] out_last);
  c_sync: cover property (s_ff.st == mdrx_pkg::MDRX_RECV && !bit_sync &&
                          s_ff.hw != mdrx_pkg::SEG_ZERO);
  c_pad: cover property (sop_take && !seg_count_ok ##[1:50] out_last);
  c_hop: cover property (hop_info_avail && hop_event);

endmodule

//--- mdrx_pkg.sv
// mdrx_pkg: shared constants and types for the multi-dwell receive framer
// assumes a single 50 MHz data clock domain for every user of this package
package mdrx_pkg;

  // segment buffer geometry
  localparam int SEG_W = 64;
  localparam int SEG_AW = 5;
  localparam logic [SEG_AW:0] SEG_DEPTH = 6'h20;
  localparam logic [SEG_AW:0] SEG_ZERO = 6'h00;
  localparam logic [SEG_AW:0] SEG_ONE = 6'h01;

  // uncorrectable segment count run limit
  localparam logic [1:0] BAD_RUN_LIMIT = 2'h3;
  localparam logic [1:0] BAD_ONE = 2'h1;

  // acknowledgement framing
  localparam logic [1:0] ACK_FRAME_FMT = 2'h3;
  localparam logic [2:0] ACK_MV_MAJOR = 3'h3;
  localparam logic [2:0] ACK_MV_MINOR = 3'h5;
  localparam logic [2:0] ACK_SEGMENTS = 3'h6;
  localparam logic [2:0] SINGLE_DWELL_SEGS = 3'h0;

  // realised rate phase accumulator
  localparam int ACC_W = 16;

  // receive control states
  typedef enum logic [1:0] {
    MDRX_IDLE,
    MDRX_RECV,
    MDRX_READ,
    MDRX_OUT
  } mdrx_state_t;

endpackage

//--- mdrx_seg_mem.sv
// mdrx_seg_mem: segment store for buffered multi-dwell data
// assumes one writer and one reader on the same clock; read data registered
`timescale 1ns/1ps
module mdrx_seg_mem (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // write side
  input wire logic wr_en,
  input wire logic [mdrx_pkg::SEG_AW-1:0] wr_addr,
  input wire logic [mdrx_pkg::SEG_W-1:0] wr_data,
  // read side
  input wire logic [mdrx_pkg::SEG_AW-1:0] rd_addr,
  output logic [mdrx_pkg::SEG_W-1:0] rd_data
);

  logic [mdrx_pkg::SEG_W-1:0] mem [0:(1 << mdrx_pkg::SEG_AW)-1];

  // array write, no reset needed on storage
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read port, cleared so the output is defined after reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

//--- mdrx_upper_sink.sv
// mdrx_upper_sink: upper protocol layer model draining released segments
// assumes the framer delivery port on the same clock, ready set after edges
`timescale 1ns/1ps
module mdrx_upper_sink (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // bench control
  input wire logic slow,
  input wire logic clr,
  // delivery port
  input wire logic out_valid,
  input wire logic [mdrx_pkg::SEG_W-1:0] out_data,
  input wire logic out_last,
  output logic out_ready,
  // capture counts
  output logic [5:0] n_got,
  output logic [5:0] n_last
);
  logic [mdrx_pkg::SEG_W-1:0] got [0:63];
  logic phase_ff;
  // accept each cycle, or every other cycle when stalling
  assign out_ready = !slow || phase_ff;
  // record accepted segments in arrival order
  always_ff @(posedge clock) begin
    phase_ff <= !phase_ff && rstn;
    if (!rstn || clr) begin
      n_got <= 6'h00;
      n_last <= 6'h00;
    end else if (out_valid && out_ready) begin
      got[n_got] <= out_data;
      n_got <= n_got + 6'h01;
      n_last <= n_last + {5'h00, out_last};
    end
  end
endmodule

//--- test_multidwell_rx_frame_end_and_hop_policy.sv
// test_multidwell_rx_frame_end_and_hop_policy: self-checking bench
// assumes mdrx_pkg and mdrx_frame_end compiled first; inputs at negedge
`timescale 1ns/1ps
module test_multidwell_rx_frame_end_and_hop_policy;
  logic clock = 0, rstn = 0, frame_start = 0, bit_sync = 1, seg_valid = 0;
  logic [63:0] seg_data = 64'h0, sd;
  logic pkt_last_bit = 0, packet_start_pattern = 0, seg_count_ok = 0;
  logic [5:0] seg_count = 6'h00, n_got, n_last;
  logic eof_flag = 0, out_valid, out_last, out_ready, hop_sync = 0;
  logic [63:0] out_data;
  logic hop_info_avail = 0, dwell_len_known = 0, dwell_long_known = 0;
  logic slot_tick = 0, hop_event, assume_hop_all, corr_window_open;
  logic [15:0] realised_rate_inc = 16'h0000;
  logic eff_bit_tick, single_block_msg = 0, ack_multidwell, slow = 0;
  logic [1:0] net_fec_cfg = 2'h2, net_dcb = 2'h1, long_dwell_fmt = 2'h1;
  logic [1:0] ack_frame_fmt, ack_fec, ack_dcb;
  logic [2:0] mv_major, mv_minor, tx_segments;
  logic clr = 0;
  int n_errors = 0, n_tests = 0;
  // free running 50 MHz clock
  always #10 clock = !clock;
  mdrx_frame_end uut (.clock(clock), .rstn(rstn),
    .frame_start(frame_start), .bit_sync(bit_sync), .seg_valid(seg_valid),
    .seg_data(seg_data), .pkt_last_bit(pkt_last_bit),
    .packet_start_pattern(packet_start_pattern), .seg_count(seg_count),
    .seg_count_ok(seg_count_ok), .eof_flag(eof_flag),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .out_ready(out_ready), .hop_sync(hop_sync),
    .hop_info_avail(hop_info_avail), .dwell_len_known(dwell_len_known),
    .dwell_long_known(dwell_long_known), .slot_tick(slot_tick),
    .hop_event(hop_event), .assume_hop_all(assume_hop_all),
    .corr_window_open(corr_window_open),
    .realised_rate_inc(realised_rate_inc), .eff_bit_tick(eff_bit_tick),
    .single_block_msg(single_block_msg), .net_fec_cfg(net_fec_cfg),
    .net_dispersive_coding_block(net_dcb), .long_dwell_fmt(long_dwell_fmt),
    .ack_multidwell(ack_multidwell), .ack_frame_fmt(ack_frame_fmt),
    .ack_message_variant_major(mv_major),
    .ack_message_variant_minor(mv_minor), .tx_segments(tx_segments),
    .ack_fec(ack_fec), .ack_dispersive_coding_block(ack_dcb));
  mdrx_upper_sink sink (.clock(clock), .rstn(rstn), .slow(slow),
    .clr(clr), .out_valid(out_valid), .out_data(out_data),
    .out_last(out_last), .out_ready(out_ready), .n_got(n_got),
    .n_last(n_last));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tick;
    @(negedge clock);
  endtask
  // new frame when fs is set, then n consecutive segments from index first
  task automatic segs(input int first, input int n, input logic fs);
    frame_start = fs;
    if (fs) tick();
    frame_start = 0;
    for (int i = first; i < first + n; i++) begin
      seg_valid = 1;
      seg_data = 64'hC0DE_0000_0000_0000 | i;
      tick();
    end
    seg_valid = 0;
  endtask
  // packet end, then a start pattern with its count fields
  task automatic pkt(input logic [5:0] cnt, input logic ok, input logic eof);
    pkt_last_bit = 1;
    tick();
    pkt_last_bit = 0;
    check(corr_window_open, 1);
    packet_start_pattern = 1;
    seg_count = cnt;
    seg_count_ok = ok;
    eof_flag = eof;
    tick();
    packet_start_pattern = 0;
    eof_flag = 0;
  endtask
  // wait for the released frame and compare it segment by segment
  task automatic drain(input int n);
    for (int w = 0; w < 300 && n_last == 0; w++) tick();
    check(n_got, n);
    check(n_last, 1);
    for (int i = 0; i < n; i++) begin
      sd = 64'hC0DE_0000_0000_0000 | i;
      check(sink.got[i], sd);
    end
    repeat (3) tick();
    check(out_valid, 0);
    clr = 1;
    tick();
    clr = 0;
  endtask
  task automatic t_eof;
    slow = 1;
    segs(0, 4, 1);
    pkt(6'h04, 1, 1);
    drain(4);
    slow = 0;
  endtask
  task automatic t_sync;
    segs(0, 3, 1);
    bit_sync = 0;
    tick();
    bit_sync = 1;
    drain(3);
  endtask
  task automatic t_bad;
    segs(0, 2, 1);
    pkt(6'h07, 0, 0);
    repeat (3) tick();
    check(out_valid, 0);
    segs(2, 2, 0);
    pkt(6'h04, 1, 1);
    drain(4);
  endtask
  // third bad count in a row, then an end flag with a bad count
  task automatic t_run;
    segs(0, 2, 1);
    repeat (3) pkt(6'h3F, 0, 0);
    drain(2);
    segs(0, 3, 1);
    pkt(6'h3F, 0, 1);
    drain(3);
  endtask
  task automatic t_hop;
    slot_tick = 1;
    tick();
    check(assume_hop_all, 1);
    check(hop_event, 1);
    hop_info_avail = 1;
    tick();
    check(assume_hop_all, 1);
    check(hop_event, 1);
    dwell_len_known = 1;
    tick();
    check(assume_hop_all, 0);
    check(hop_event, 0);
    slot_tick = 0;
    hop_sync = 1;
    tick();
    check(hop_event, 1);
    tick();
    check(hop_event, 0);
    check({ack_multidwell, ack_frame_fmt}, 3'h7);
    check({mv_major, mv_minor, tx_segments}, 9'h0EE);
    check({ack_fec, ack_dcb}, 4'h9);
    dwell_long_known = 1;
    tick();
    check({ack_multidwell, ack_frame_fmt, tx_segments}, 6'h08);
    single_block_msg = 1;
    tick();
    check(tx_segments, 3'h6);
  endtask
  // realised rate ticks counted over sixteen cycles
  task automatic t_rate(input logic [15:0] inc, input int exp);
    int c;
    c = 0;
    realised_rate_inc = inc;
    repeat (3) tick();
    for (int i = 0; i < 16; i++) begin
      tick();
      c += eff_bit_tick;
    end
    check(c, exp);
  endtask
  // reset, scenarios, verdict
  initial begin
    repeat (2) tick();
    check({out_valid, assume_hop_all, tx_segments}, 5'h0E);
    rstn = 1;
    t_eof();
    t_sync();
    t_bad();
    t_run();
    t_hop();
    t_rate(16'h8000, 8);
    t_rate(16'h4000, 4);
    summarize();
  end
  // watchdog against a hung handshake
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
endmodule
